// [testbench.sv]
// Self-checking bench of the pipe descriptor block.
// Assumes the checker and the RAM model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, in_data_i, ram_addr_o, ram_data_o, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic hs_mode_i, usb_reset_i, txn_start_i, txn_bank_i, txn_done_i, txn_in_i;
   logic in_valid_i, in_ready_o, ram_valid_o, ram_ready_i, zlp_req_o, stall;
   logic [10:0] txn_bytes_i, max_pkt_o, e;
   logic [33:0] exp_q[$];
   logic [31:0] dq[$], exp_addr;
   int err_count, total_checks, zlp_cnt, seed, i, n, c;
   uhpd_desc u_dut (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(s_axi_awprot),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(s_axi_arprot),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .hs_mode_i(hs_mode_i),
      .usb_reset_i(usb_reset_i),
      .txn_start_i(txn_start_i),
      .txn_bank_i(txn_bank_i),
      .txn_done_i(txn_done_i),
      .txn_in_i(txn_in_i),
      .txn_bytes_i(txn_bytes_i),
      .max_pkt_o(max_pkt_o),
      .zlp_req_o(zlp_req_o),
      .in_valid_i(in_valid_i),
      .in_ready_o(in_ready_o),
      .in_data_i(in_data_i),
      .ram_valid_o(ram_valid_o),
      .ram_ready_i(ram_ready_i),
      .ram_addr_o(ram_addr_o),
      .ram_data_o(ram_data_o)
   );
   uhpd_ram_model u_ram (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .stall_i(stall),
      .ram_ready_o(ram_ready_i)
   );
   always #2 core_clk_i = ~core_clk_i;
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test(input bit hung);
      if (hung) err_count++;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      @(posedge core_clk_i);
      exp_q.push_back({32'h0, r});
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge core_clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) stop_test(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] x);
      @(posedge core_clk_i);
      exp_q.push_back(x);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge core_clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 50) stop_test(1);
   endtask
   // One engine pulse: a start on a bank, or a done with its bytes.
   task automatic eng(input logic st, input logic b, input logic in, input logic [10:0] nb);
      @(posedge core_clk_i);
      txn_start_i <= st;
      txn_done_i <= !st;
      txn_bank_i <= b;
      txn_in_i <= in;
      txn_bytes_i <= nb;
      @(posedge core_clk_i);
      txn_start_i <= 1'b0;
      txn_done_i <= 1'b0;
   endtask
   task automatic feed(input int cnt);
      in_valid_i <= 1'b1;
      in_data_i <= $random(seed);
      for (n = 0; n < 300 && cnt > 0; n++) begin
         @(posedge core_clk_i);
         if (in_ready_o) begin
            cnt--;
            in_data_i <= $random(seed);
            in_valid_i <= cnt > 0;
         end
      end
      if (cnt > 0) stop_test(1);
   endtask
   // Results are matched against the oldest note as they appear.
   always @(posedge core_clk_i) begin
      if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, exp_q.pop_front());
      if (s_axi_rvalid && s_axi_rready) chk({s_axi_rdata, s_axi_rresp}, exp_q.pop_front());
      if (in_valid_i && in_ready_o) dq.push_back(in_data_i);
      if (ram_valid_o && ram_ready_i) begin
         chk({2'h0, ram_addr_o}, {2'h0, exp_addr});
         chk({2'h0, ram_data_o}, {2'h0, dq.pop_front()});
         exp_addr = exp_addr + 32'h4;
      end
      if (zlp_req_o) zlp_cnt++;
   end
   initial begin
      seed = 63;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
         s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, hs_mode_i,
         usb_reset_i, txn_start_i, txn_bank_i, txn_done_i, txn_in_i, txn_bytes_i,
         in_valid_i, in_data_i, stall} = '0;
      repeat (4) @(posedge core_clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 4; i++) rd({3'h0, i[1], 1'b0, i[0], 2'h0}, 34'h0);
      rd(8'h08, 34'h2);
      wr(8'h08, 32'h1, 2'h2);
      wr(8'h00, 32'hffffffff, 2'h0);
      rd(8'h00, {32'hfffffffc, 2'h0});
      d = $random(seed);
      wr(8'h14, d, 2'h0);
      rd(8'h14, {d, 2'h0});
      // every size code in both speeds.
      // codes 4 to 7 here stand for an isochronous pipe.
      for (i = 0; i < 16; i++) begin
         hs_mode_i <= i[3];
         wr(8'h04, {1'b0, i[2:0], 28'h0}, 2'h0);
         eng(1, 0, 0, 11'h0);
         repeat (2) @(posedge core_clk_i);
         e = (i[2:0] == 3'h7) ? (i[3] ? 11'h400 : 11'h3ff) : (11'h8 << i[2:0]);
         chk({23'h0, max_pkt_o}, {23'h0, e});
      end
      // bus reset clears only the size fields.
      d = $random(seed);
      wr(8'h04, d, 2'h0);
      wr(8'h14, d, 2'h0);
      @(posedge core_clk_i);
      usb_reset_i <= 1'b1;
      @(posedge core_clk_i);
      usb_reset_i <= 1'b0;
      rd(8'h04, {d & 32'h8fffffff, 2'h0});
      rd(8'h14, {d & 32'h8fffffff, 2'h0});
      // stream to the bank pointer; fill until refused, then drain.
      exp_addr = {$random(seed)} & 32'hfffffffc;
      wr(8'h10, exp_addr, 2'h0);
      wr(8'h14, 32'h0, 2'h0);
      eng(1, 1, 1, 11'h0);
      stall <= 1'b1;
      feed(16);
      #1;
      chk({33'h0, in_ready_o}, 34'h0);
      stall <= 1'b0;
      for (n = 0; n < 300 && (ram_valid_o || n < 2); n++) @(posedge core_clk_i);
      chk({33'h0, ram_valid_o}, 34'h0);
      // IN bytes add to the total.
      eng(0, 1, 1, 11'd100);
      eng(0, 1, 1, 11'd100);
      rd(8'h14, {32'd200 << 14, 2'h0});
      // zero-length request: off, on for OUT, never for IN.
      eng(1, 0, 0, 11'h0);
      for (i = 0; i < 3; i++) begin
         c = zlp_cnt;
         wr(8'h04, {i != 0, 31'h40000}, 2'h0);
         eng(0, 0, i == 2, 11'd8);
         eng(0, 0, i == 2, 11'd8);
         repeat (3) @(posedge core_clk_i);
         chk(34'(zlp_cnt - c), {33'h0, i == 1});
         if (i == 1) rd(8'h04, {32'h80040008, 2'h0});
      end
      rd(8'h04, {32'h80080000, 2'h0});
      stop_test(0);
   end
endmodule // testbench
bind uhpd_desc uhpd_desc_props u_props (
   .core_clk_i(core_clk_i),
   .rst_i(rst_i),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata),
   .usb_reset_i(usb_reset_i),
   .txn_start_i(txn_start_i),
   .max_pkt_o(max_pkt_o),
   .zlp_req_o(zlp_req_o),
   .ram_valid_o(ram_valid_o),
   .ram_ready_i(ram_ready_i),
   .ram_addr_o(ram_addr_o),
   .ram_data_o(ram_data_o)
);
`default_nettype wire

// [uhpd_cfg.svh]
// Register offsets, field positions, reset values and sizes of the pipe descriptor.
// Assumes it is included by bare name, once per compilation unit or guarded.
`ifndef UHPD_CFG_SVH
`define UHPD_CFG_SVH

`define UHPD_ADDR_W 8
`define UHPD_OFF_B0_PTR 8'h00
`define UHPD_OFF_B0_PKS 8'h04
`define UHPD_OFF_B1_PTR 8'h10
`define UHPD_OFF_B1_PKS 8'h14

`define UHPD_AZLP_BIT 31
`define UHPD_SIZE_HI 30
`define UHPD_SIZE_LO 28
`define UHPD_MPS_HI 27
`define UHPD_MPS_LO 14
`define UHPD_BC_HI 13
`define UHPD_BC_LO 0

`define UHPD_PTR_RST 32'h0000_0000
`define UHPD_PKS_RST 32'h0000_0000

`define UHPD_RESP_OKAY 2'h0
`define UHPD_RESP_SLVERR 2'h2

`define UHPD_FIFO_W 32
`define UHPD_FIFO_D 16

`endif

// [uhpd_desc.sv]
// Host pipe descriptor, two banks, reached over AXI4-Lite, with a data stream to RAM.
// Assumes a pipe engine on the same clock that signals transaction start and end,
// and a RAM write port that may stall.
//
// Operation
// (RULE1) Bank pointer is the absolute RAM address for that bank's packet data.
// (RULE2) Software keeps pointer word aligned; the two low bits read zero.
// (RULE3) Auto zero-length bit set makes hardware request the zero-length packet.
// (RULE4) Auto zero-length handling applies to OUT pipes only.
// (RULE5) Size codes 0 to 6 mean 8 up to 512 bytes.
// (RULE6) Software uses size codes 4 to 7 only for isochronous pipes.
// (RULE7) Size code 7 means 1024 bytes high speed, 1023 full speed.
// (RULE8) Sending a bus reset clears both size fields.
// (RULE9) Bits 27 to 14 hold the 14-bit multi-packet total.
// (RULE10) IN transactions add their bytes to the multi-packet total.
// (RULE11) Software clears the multi-packet total before each new IN transfer.
// (RULE12) Software loads OUT total as a multiple of the maximum packet size.
// (RULE13) Byte count holds last OUT/SETUP bytes or next IN expected bytes.
// (RULE14) Software initialises every descriptor field before enabling the pipe.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "uhpd_cfg.svh"

module uhpd_desc
   import uhpd_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   // AXI4-Lite slave.
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Pipe engine side.
   input wire logic hs_mode_i,
   input wire logic usb_reset_i,
   input wire logic txn_start_i,
   input wire logic txn_bank_i,
   input wire logic txn_done_i,
   input wire logic txn_in_i,
   input wire logic [10:0] txn_bytes_i,
   output logic [10:0] max_pkt_o,
   output logic zlp_req_o,
   // Packet data stream into the buffer, then out to RAM.
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [31:0] in_data_i,
   output logic ram_valid_o,
   input wire logic ram_ready_i,
   output logic [31:0] ram_addr_o,
   output logic [31:0] ram_data_o
);

   uhpd_state_t st_ff;
   uhpd_state_t nxt_st;
   logic fifo_valid;
   logic ram_take;
   logic [31:0] fifo_data;
   // Protection bits on both address channels are accepted and ignored: the
   // descriptor words carry no privilege split, so every access type may reach them.

   // Decode a size code into bytes; code 7 depends on the bus speed.
   // Codes 0 to 6 double from eight bytes; only the top code needs the speed.
   function automatic logic [10:0] size_bytes(input logic [2:0] code, input logic hs);
      logic [10:0] b;
      b = 11'h008 << code;
      // (RULE7) speed-dependent top size
      if (code == 3'h7) begin
         b = hs ? 11'h400 : 11'h3ff;
      end
      return b;
   endfunction

   // Byte-lane merge of a write into a stored word.
   // Unwritten lanes keep their old bytes, so software may update one byte lane of a word alone.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Byte address of a stored word pointer; the two low bits are wired to zero.
   function automatic logic [31:0] word_to_byte(input logic [29:0] w);
      return {w, 2'b00};
   endfunction

   // Address decode: bank index, whether size word, and whether mapped.
   // Bit 2 flags a mapped word, bit 1 picks the bank and bit 0 the size word.
   function automatic logic [2:0] decode(input logic [7:0] a);
      logic [2:0] d;
      unique case (a)
         `UHPD_OFF_B0_PTR: d = 3'b100;
         `UHPD_OFF_B0_PKS: d = 3'b101;
         `UHPD_OFF_B1_PTR: d = 3'b110;
         `UHPD_OFF_B1_PKS: d = 3'b111;
         default: d = 3'b000;
      endcase
      return d;
   endfunction

   // The buffer sits between the engine's packet stream and the RAM port.
   // It absorbs short RAM stalls so the engine need not stop mid-packet; a stall
   // longer than sixteen words still backs up into the engine through in_ready_o.
   uhpd_fifo #(
      .W(`UHPD_FIFO_W),
      .D(`UHPD_FIFO_D)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .in_valid_i(in_valid_i),
      .in_ready_o(in_ready_o),
      .in_data_i(in_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(ram_ready_i),
      .out_data_o(fifo_data)
   );

   // Handshake outputs are combinational; data and addresses come from flops.
   assign ram_valid_o = fifo_valid;
   // The take mirrors the buffer's pop, so the address steps with each word taken.
   assign ram_take = fifo_valid & ram_ready_i;
   assign ram_data_o = fifo_data;
   // (RULE1) word address from the pointer
   assign ram_addr_o = word_to_byte(st_ff.ram_addr_w);
   // Readies are combinational so a request is taken in the cycle it is offered;
   // responses come from flops and stand until the master takes them.
   assign s_axi_awready = ~st_ff.aw_hold & ~st_ff.bvalid;
   assign s_axi_wready = ~st_ff.w_hold & ~st_ff.bvalid;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = ~st_ff.rvalid;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign max_pkt_o = st_ff.max_pkt;
   assign zlp_req_o = st_ff.zlp_req;

   // Next-state logic: bus slave first, then engine updates, then bus reset,
   // so hardware events in the same cycle as a software write are not lost.
   always_comb begin
      logic [2:0] dw;
      logic [2:0] dr;
      logic b;
      logic [31:0] old;
      logic [31:0] nw;
      logic [13:0] sent_new;
      dw = decode(st_ff.aw_addr);
      dr = decode(s_axi_araddr);
      b = st_ff.act_bank;
      old = '0;
      nw = '0;
      sent_new = '0;
      nxt_st = st_ff;
      nxt_st.zlp_req = 1'b0;

      // Capture address and data in whichever order they arrive.
      // A half that arrives first waits in its flops until the other one is taken.
      if (s_axi_awvalid & s_axi_awready) begin
         nxt_st.aw_hold = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         nxt_st.w_hold = 1'b1;
         nxt_st.w_data = s_axi_wdata;
         nxt_st.w_strb = s_axi_wstrb;
      end
      if (st_ff.bvalid & s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end

      // Perform the write once both halves are held; unmapped gives SLVERR.
      // Only full 32-bit words are mapped; byte strobes merge into the stored word.
      // While bvalid stands both readies are low, so a second write cannot slip in
      // and change the response the master has not yet taken.
      if (st_ff.aw_hold & st_ff.w_hold) begin
         nxt_st.aw_hold = 1'b0;
         nxt_st.w_hold = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = dw[2] ? `UHPD_RESP_OKAY : `UHPD_RESP_SLVERR;
         if (dw[2] & ~dw[0]) begin
            old = word_to_byte(st_ff.bank[dw[1]].ptr_w);
            nw = merge(old, st_ff.w_data, st_ff.w_strb);
            // (RULE2) low pointer bits stay zero
            nxt_st.bank[dw[1]].ptr_w = nw[31:2];
         end else if (dw[2]) begin
            old = st_ff.bank[dw[1]].pks;
            nw = merge(old, st_ff.w_data, st_ff.w_strb);
            // (RULE9) store the multi-packet field
            nxt_st.bank[dw[1]].pks = nw;
            nxt_st.bank[dw[1]].sent = '0;
         end
      end

      // Reads answer one cycle after the address is taken.
      // The data is the word as it stood at the edge the request was taken; a write
      // landing on that same edge shows up on the next read.
      if (st_ff.rvalid & s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid & ~st_ff.rvalid) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = dr[2] ? `UHPD_RESP_OKAY : `UHPD_RESP_SLVERR;
         nxt_st.rdata = '0;
         if (dr[2] & ~dr[0]) begin
            nxt_st.rdata = word_to_byte(st_ff.bank[dr[1]].ptr_w);
         end else if (dr[2]) begin
            nxt_st.rdata = st_ff.bank[dr[1]].pks;
         end
      end

      // A new transaction points the RAM stream at its bank's buffer.
      // A start on the cycle a pointer write lands takes the new pointer, since it
      // reads the next-state copy; the engine never sees a stale buffer address.
      // Limitation: words still buffered from an earlier packet follow the new
      // address, so the engine starts a transaction only with the buffer drained.
      if (txn_start_i) begin
         b = txn_bank_i;
         nxt_st.act_bank = txn_bank_i;
         // (RULE1) buffer start address
         nxt_st.ram_addr_w = nxt_st.bank[txn_bank_i].ptr_w;
      end else if (ram_take) begin
         nxt_st.ram_addr_w = st_ff.ram_addr_w + 30'h1;
      end

      // End of a transaction updates the active bank's counts.
      // The multi-packet total wraps at 14 bits; software keeps transfers below that.
      // The hardware sent total is kept apart from the fields software owns, so a
      // read of the size word mid-transfer never shows internal bookkeeping.
      if (txn_done_i) begin
         if (txn_in_i) begin
            // (RULE10) running IN byte total
            nxt_st.bank[b].pks.mps = nxt_st.bank[b].pks.mps + 14'(txn_bytes_i);
         end else begin
            // (RULE13) bytes sent last OUT
            nxt_st.bank[b].pks.bc = 14'(txn_bytes_i);
            sent_new = nxt_st.bank[b].sent + 14'(txn_bytes_i);
            nxt_st.bank[b].sent = sent_new;
            // The request fires only when the last OUT packet was a full one and the
            // whole programmed total has gone; a short packet already ends the transfer.
            // (RULE3) hardware zero-length request
            // (RULE4) OUT pipes only
            if (nxt_st.bank[b].pks.azlp && sent_new == nxt_st.bank[b].pks.mps
                && txn_bytes_i == st_ff.max_pkt) begin
               nxt_st.zlp_req = 1'b1;
            end
         end
      end

      // Bus reset comes last so it overrides a same-cycle software write of the size.
      // Only the size field is cleared; the other fields keep their values.
      // (RULE8) bus reset clears size
      if (usb_reset_i) begin
         nxt_st.bank[0].pks.size = 3'h0;
         nxt_st.bank[1].pks.size = 3'h0;
      end

      // Decoded from the next state, so the engine sees a new size on the same edge
      // that the write lands; hs_mode_i is read live for the same reason.
      // (RULE5) decode size for engine
      nxt_st.max_pkt = size_bytes(nxt_st.bank[nxt_st.act_bank].pks.size, hs_mode_i);
   end

   // Descriptor words power up cleared so nothing downstream sees unknowns.
   // Reset clears more than the hardware strictly needs: the bus slave and the
   // RAM address must start idle, and zeroed words keep every read defined.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
         st_ff.bank[0].pks <= `UHPD_PKS_RST;
         st_ff.bank[1].pks <= `UHPD_PKS_RST;
         st_ff.bank[0].ptr_w <= 30'(`UHPD_PTR_RST >> 2);
         st_ff.bank[1].ptr_w <= 30'(`UHPD_PTR_RST >> 2);
         st_ff.max_pkt <= 11'h008;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule // uhpd_desc

`default_nettype wire

// [uhpd_desc_props.sv]
// Checker of the pipe descriptor block's ports.
// Assumes a bind to uhpd_desc, one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module uhpd_desc_props (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic usb_reset_i,
   input wire logic txn_start_i,
   input wire logic [10:0] max_pkt_o,
   input wire logic zlp_req_o,
   input wire logic ram_valid_o,
   input wire logic ram_ready_i,
   input wire logic [31:0] ram_addr_o,
   input wire logic [31:0] ram_data_o
);
   // One clock domain, so clocking and reset are stated once.
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // Answers stand until taken, or software loses a status.
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write status dropped");
   a_ram_aligned: assert property (ram_valid_o |->
      ram_addr_o[1:0] == 2'h0) else $error("ram address not aligned");
   a_ram_step: assert property (ram_valid_o && ram_ready_i && !txn_start_i |=>
      ram_addr_o == $past(ram_addr_o) + 32'h4) else $error("ram address step wrong");
   a_ram_hold: assert property (ram_valid_o && !ram_ready_i |=> ram_valid_o &&
      $stable(ram_addr_o) && $stable(ram_data_o)) else $error("ram word dropped");
   a_size_table: assert property (max_pkt_o inside {11'h8, 11'h10, 11'h20,
      11'h40, 11'h80, 11'h100, 11'h200, 11'h3ff, 11'h400}) else $error("bad size");
   a_size_clear: assert property (usb_reset_i |-> ##2
      max_pkt_o == 11'h8) else $error("bus reset kept size");
   a_zlp_pulse: assert property (zlp_req_o |=> !zlp_req_o)
      else $error("zero-length request too long");
endmodule // uhpd_desc_props
`default_nettype wire

// [uhpd_fifo.sv]
// Synchronous FIFO with valid/ready on both sides and honest full/empty.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module uhpd_fifo #(
   parameter int W = 32,
   parameter int D = 16
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } uhpd_fifo_st_t;

   uhpd_fifo_st_t st_ff;
   uhpd_fifo_st_t nxt_st;
   logic push;
   logic pop;

   // Full is a count of D, so a write is refused until the drain side moves.
   assign in_ready_o = (st_ff.cnt != (AW+1)'(D));
   assign out_valid_o = (st_ff.cnt != '0);
   assign out_data_o = st_ff.mem[st_ff.rp];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // Pointers wrap naturally because D is a power of two.
   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wp] = in_data_i;
         nxt_st.wp = st_ff.wp + AW'(1);
      end
      if (pop) begin
         nxt_st.rp = st_ff.rp + AW'(1);
      end
      if (push & ~pop) begin
         nxt_st.cnt = st_ff.cnt + (AW+1)'(1);
      end else if (pop & ~push) begin
         nxt_st.cnt = st_ff.cnt - (AW+1)'(1);
      end
   end

   // Storage is not cleared by reset and still takes a push; only pointers and count are cleared.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_ff.wp <= '0;
         st_ff.rp <= '0;
         st_ff.cnt <= '0;
         st_ff.mem <= nxt_st.mem;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule // uhpd_fifo

`default_nettype wire

// [uhpd_pkg.sv]
// Types of the pipe descriptor block; its stream buffer defines its own.
// Assumes uhpd_cfg.svh is reachable on the include path.
`default_nettype none
package uhpd_pkg;

   // Packet size word as it sits in the descriptor.
   typedef struct packed {
      logic azlp;
      logic [2:0] size;
      logic [13:0] mps;
      logic [13:0] bc;
   } uhpd_pks_t;

   // One bank: word pointer (two low bits are always zero), size word and hardware sent total.
   typedef struct packed {
      logic [29:0] ptr_w;
      uhpd_pks_t pks;
      logic [13:0] sent;
   } uhpd_bank_t;

   // Whole state of the descriptor block.
   typedef struct packed {
      uhpd_bank_t [1:0] bank;
      logic aw_hold;
      logic [7:0] aw_addr;
      logic w_hold;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic act_bank;
      logic [29:0] ram_addr_w;
      logic [10:0] max_pkt;
      logic zlp_req;
   } uhpd_state_t;

endpackage : uhpd_pkg

`default_nettype wire

// [uhpd_ram_model.sv]
// RAM write port model on the far side of the packet stream.
// Assumes the bench's stall input holds it off to fill the buffer.
`timescale 1ns/1ps
`default_nettype none
module uhpd_ram_model (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic stall_i,
   output logic ram_ready_o
);
   int seed = 63;
   // Ready wanders, so words are taken both promptly and slowly.
   always @(posedge core_clk_i) begin
      if (rst_i || stall_i)
         ram_ready_o <= 1'b0;
      else
         ram_ready_o <= ($random(seed) % 3) != 0;
   end
endmodule // uhpd_ram_model
`default_nettype wire
